/* File: design/ahp_port.sv */
// Purpose: 16-bit asynchronous memory-style host port with dma steering
// Assumes: address, data and byte lanes stable while a strobe is low
// Notes:   register contents live behind the user-side register port
`timescale 1ns/1ns
`include "ahp_consts.svh"

// How it works
// [R01] access counts only while select is low
// [R02] seven address lines pick one word
// [R03] master raises dma select for buffer dma
// [R04] master keeps dma select low otherwise
// [R05] read strobe low drives addressed word out
// [R06] write strobe low captures bus data
// [R07] byte lane enables gate each written byte
// [R08] interrupt low, push-pull or open-collector
// [R09] reset acts asynchronously on whole port
// [R10] system clock times the host interface
// [R11] bus turns around between reads, writes
// [R12] dma select high means buffer port
// [R13] alternate port zero then one, even count
// [R14] dma request follows receive buffer fill
// [R15] strobes ignored unselected, bus released idle
// [R16] strobes synchronised, one access per strobe
module ahp_port
   import ahp_pkg::*;
(
   // clock and reset
   input  wire logic               I_CLK_SYS,
   input  wire logic               I_RST,
   // host bus pins
   input  wire logic               I_CS_N,
   input  wire logic               I_READ_STROBE_N,
   input  wire logic               I_WRITE_STROBE_N,
   input  wire logic [6:0]         I_ADDR,
   input  wire logic               I_BUFFER_DMA_SELECT,
   input  wire logic [1:0]         I_BYTE_LANE_EN_N,
   input  wire ahp_pkg::ahp_word_t I_DATA_I,
   output ahp_pkg::ahp_word_t      O_DATA_O,
   output logic                    O_DATA_OE,
   // interrupt and dma request pins
   output logic                    O_INT_N_O,
   output logic                    O_INT_N_OE,
   output logic                    O_DMA_REQUEST,
   // register space side
   output ahp_pkg::ahp_waddr_t     O_REG_ADDR,
   output ahp_pkg::ahp_word_t      O_REG_WDATA,
   output logic [1:0]              O_REG_BYTE_EN,
   output logic                    O_REG_WR,
   output logic                    O_REG_RD,
   input  wire ahp_pkg::ahp_word_t I_REG_RDATA,
   // controller status and settings
   input  wire logic               I_IRQ,
   input  wire logic               I_INT_OPEN_COLLECTOR,
   input  wire logic               I_DMA_ENABLE,
   input  wire ahp_pkg::ahp_burst_t I_DMA_BURST,
   input  wire ahp_pkg::ahp_delay_t I_DMA_GAP,
   input  wire logic               I_SD_CLK_EN,
   input  wire ahp_pkg::ahp_level_t I_RX_LEVEL
);

   logic [2:0]  sync_w;        // synchronised cs, read, write strobes
   logic        cs_n_s;        // synchronised select
   logic        rd_n_s;        // synchronised read strobe
   logic        wr_n_s;        // synchronised write strobe
   ahp_acc_e    state_reg;     // access sequencer
   ahp_acc_e    state_next;
   logic        port_sel_reg;  // next buffer port: 0 or 1
   ahp_burst_t  burst_cnt_reg; // dma reads done in this burst
   ahp_delay_t  gap_cnt_reg;   // sd clocks left in the gap
   logic        gap_reg;       // dma request held low
   logic        rd_hold_reg;   // read data is being driven

   // one synchroniser for all three strobes
   ahp_sync #(.W(3)) u_sync
   (
      .i_clk   (I_CLK_SYS),
      .i_rst   (I_RST),
      .i_async ({I_CS_N, I_READ_STROBE_N, I_WRITE_STROBE_N}),
      .o_sync  (sync_w)
   );

   assign cs_n_s = sync_w[2];
   assign rd_n_s = sync_w[1];
   assign wr_n_s = sync_w[0];

   // decode of a new access
   wire sel_w     = ~cs_n_s;                                 // [R01] [R15]
   wire rd_go_w   = sel_w & ~rd_n_s & wr_n_s;                // [R05]
   wire wr_go_w   = sel_w & ~wr_n_s & rd_n_s;                // [R06]
   wire start_w   = (state_reg == AHP_IDLE) & (rd_go_w | wr_go_w);
   wire is_dma_w  = I_DMA_ENABLE & I_BUFFER_DMA_SELECT;      // [R12]
   wire dma_acc_w = start_w & is_dma_w;
   wire dma_rd_w  = dma_acc_w & rd_go_w;
   wire burst_done_w = dma_rd_w & ((burst_cnt_reg + 9'h001) >= I_DMA_BURST);

   // address steering: buffer port alternates under dma
   wire ahp_waddr_t port_addr_w = port_sel_reg ? `AHP_PORT1_WADDR : `AHP_PORT0_WADDR; // [R13]
   wire ahp_waddr_t addr_w      = is_dma_w ? port_addr_w : I_ADDR;                    // [R02] [R12]

   // dma request: enough receive words, not in gap
   wire dma_request_next = I_DMA_ENABLE & ~gap_reg & ~burst_done_w & (I_DMA_BURST != `AHP_BURST_RST)
                           & (I_RX_LEVEL != 11'h000)
                           & (I_RX_LEVEL >= {2'b00, I_DMA_BURST});  // [R14]

   // sequencer: one access per strobe, wait for release
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         AHP_IDLE:
         begin
            if (rd_go_w)
               state_next = AHP_READ;
            else if (wr_go_w)
               state_next = AHP_WRITE;
         end
         AHP_READ:
         begin
            if (rd_n_s | cs_n_s)
               state_next = AHP_IDLE;                        // [R16]
         end
         AHP_WRITE:
         begin
            if (wr_n_s | cs_n_s)
               state_next = AHP_IDLE;                        // [R16]
         end
         default:
            state_next = AHP_IDLE;
      endcase
   end

   // state and register-side strobes
   always_ff @(posedge I_CLK_SYS or posedge I_RST)   // [R09] [R10]
   begin
      if (I_RST)
      begin
         state_reg     <= AHP_IDLE;
         O_REG_RD      <= 1'b0;
         O_REG_WR      <= 1'b0;
         O_REG_ADDR    <= `AHP_WADDR_RST;
         O_REG_WDATA   <= `AHP_DATA_RST;
         O_REG_BYTE_EN <= 2'b00;
      end
      else
      begin
         state_reg <= state_next;
         O_REG_RD  <= start_w & rd_go_w;                            // [R05] [R16]
         O_REG_WR  <= start_w & wr_go_w & ~(&I_BYTE_LANE_EN_N);    // [R06] [R16]
         if (start_w)
         begin
            O_REG_ADDR    <= addr_w;
            O_REG_WDATA   <= I_DATA_I;
            O_REG_BYTE_EN <= wr_go_w ? ~I_BYTE_LANE_EN_N : 2'b00;  // [R07]
         end
      end
   end

   // drive stays on while the same read strobe is still seen low
   wire rd_keep_w = O_REG_RD | (rd_hold_reg & (state_reg == AHP_READ) & ~rd_n_s & ~cs_n_s);

   // read data drive: load the word, hold it until the strobe lifts
   always_ff @(posedge I_CLK_SYS or posedge I_RST)
   begin
      if (I_RST)
      begin
         rd_hold_reg <= 1'b0;
         O_DATA_OE   <= 1'b0;
         O_DATA_O    <= `AHP_DATA_RST;
      end
      else
      begin
         if (O_REG_RD)
            O_DATA_O <= I_REG_RDATA;                          // [R05] [R11]
         rd_hold_reg <= rd_keep_w;
         O_DATA_OE   <= rd_keep_w;                             // [R15] [R11]
      end
   end

   // buffer port alternation and burst gap
   always_ff @(posedge I_CLK_SYS or posedge I_RST)
   begin
      if (I_RST)
      begin
         port_sel_reg  <= 1'b0;
         burst_cnt_reg <= `AHP_BURST_RST;
         gap_cnt_reg   <= `AHP_DELAY_RST;
         gap_reg       <= 1'b0;
         O_DMA_REQUEST <= 1'b0;
      end
      else
      begin
         O_DMA_REQUEST <= dma_request_next;                    // [R14]
         if (!I_DMA_ENABLE)
            port_sel_reg <= 1'b0;                              // [R13]
         else if (dma_acc_w)
            port_sel_reg <= ~port_sel_reg;                     // [R13]
         if (burst_done_w | !I_DMA_ENABLE)
            burst_cnt_reg <= `AHP_BURST_RST;
         else if (dma_rd_w)
            burst_cnt_reg <= burst_cnt_reg + 9'h001;
         if (burst_done_w)
         begin
            gap_reg     <= (I_DMA_GAP != `AHP_DELAY_RST);
            gap_cnt_reg <= I_DMA_GAP;
         end
         else if (gap_reg & I_SD_CLK_EN)
         begin
            gap_cnt_reg <= gap_cnt_reg - 7'h01;
            gap_reg     <= (gap_cnt_reg != 7'h01);
         end
      end
   end

   // interrupt pin: push-pull drives both levels, open-collector only low
   always_ff @(posedge I_CLK_SYS or posedge I_RST)
   begin
      if (I_RST)
      begin
         O_INT_N_O  <= 1'b1;
         O_INT_N_OE <= 1'b0;
      end
      else
      begin
         O_INT_N_O  <= I_INT_OPEN_COLLECTOR ? 1'b0 : ~I_IRQ;   // [R08]
         O_INT_N_OE <= I_INT_OPEN_COLLECTOR ? I_IRQ : 1'b1;    // [R08]
      end
   end

   // checks on the port behaviour
   chk_unsel_no_access: assert property (@(posedge I_CLK_SYS) disable iff (I_RST) // [R01]
      $past(cs_n_s) |-> !O_REG_RD && !O_REG_WR)
      else $error("access issued while unselected");
   chk_read_one_pulse: assert property (@(posedge I_CLK_SYS) disable iff (I_RST) // [R16]
      O_REG_RD |=> !O_REG_RD)
      else $error("read pulse longer than one cycle");
   chk_write_one_pulse: assert property (@(posedge I_CLK_SYS) disable iff (I_RST) // [R16]
      O_REG_WR |=> !O_REG_WR ##1 !O_REG_WR)
      else $error("write repeated for one strobe");
   chk_read_drives_bus: assert property (@(posedge I_CLK_SYS) disable iff (I_RST) // [R05]
      O_REG_RD |=> O_DATA_OE && O_DATA_O == $past(I_REG_RDATA))
      else $error("read word not driven");
   chk_bus_released: assert property (@(posedge I_CLK_SYS) disable iff (I_RST) // [R15]
      O_DATA_OE && !$past(O_REG_RD) |-> $past(state_reg) == AHP_READ)
      else $error("bus driven outside a read");
   chk_byte_lanes: assert property (@(posedge I_CLK_SYS) disable iff (I_RST) // [R07]
      O_REG_WR |-> O_REG_BYTE_EN == ~$past(I_BYTE_LANE_EN_N))
      else $error("byte lanes wrong on write");
   chk_dma_port_addr: assert property (@(posedge I_CLK_SYS) disable iff (I_RST) // [R12]
      (O_REG_RD || O_REG_WR) && $past(is_dma_w)
      |-> O_REG_ADDR == `AHP_PORT0_WADDR || O_REG_ADDR == `AHP_PORT1_WADDR)
      else $error("dma access not steered to buffer port");
   chk_port_alternate: assert property (@(posedge I_CLK_SYS) disable iff (I_RST) // [R13]
      dma_acc_w && I_DMA_ENABLE |=> port_sel_reg != $past(port_sel_reg))
      else $error("buffer port did not alternate");
   chk_request_empty: assert property (@(posedge I_CLK_SYS) disable iff (I_RST) // [R14]
      $past(I_RX_LEVEL) == 11'h000 |-> !O_DMA_REQUEST)
      else $error("dma request with empty buffer");
   chk_int_style: assert property (@(posedge I_CLK_SYS) disable iff (I_RST) // [R08]
      !$past(I_RST) && $past(I_IRQ) |-> O_INT_N_OE && !O_INT_N_O)
      else $error("interrupt not driven low");

endmodule

/* File: design/ahp_consts.svh */
// Purpose: constants of the asynchronous host bus port
// Assumes: included by the package and the port module
// Notes:   word addresses index 16-bit locations of the 256-byte space
`ifndef AHP_CONSTS_SVH
`define AHP_CONSTS_SVH

// bus widths
`define AHP_DATA_W        16
`define AHP_WADDR_W       7
`define AHP_BURST_W       9
`define AHP_DELAY_W       7
`define AHP_LEVEL_W       11

// buffer data ports as word addresses (byte 0x20 and 0x22)
`define AHP_PORT0_WADDR   7'h10
`define AHP_PORT1_WADDR   7'h11

// reset values
`define AHP_DATA_RST      16'h0000
`define AHP_WADDR_RST     7'h00
`define AHP_BURST_RST     9'h000
`define AHP_DELAY_RST     7'h00

`endif

/* File: design/ahp_pkg.sv */
// Purpose: types shared by the asynchronous host bus port
// Assumes: constants come from ahp_consts.svh
// Notes:   holds types only
`include "ahp_consts.svh"

package ahp_pkg;

   typedef logic [`AHP_DATA_W-1:0]  ahp_word_t;   // one bus word
   typedef logic [`AHP_WADDR_W-1:0] ahp_waddr_t;  // word address
   typedef logic [`AHP_BURST_W-1:0] ahp_burst_t;  // burst length in words
   typedef logic [`AHP_DELAY_W-1:0] ahp_delay_t;  // gap length in sd clocks
   typedef logic [`AHP_LEVEL_W-1:0] ahp_level_t;  // buffer fill in words

   // access sequencer states
   typedef enum logic [1:0]
   {
      AHP_IDLE,
      AHP_READ,
      AHP_WRITE
   } ahp_acc_e;

endpackage

/* File: design/ahp_sync.sv */
// Purpose: two-stage synchroniser for the asynchronous bus strobes
// Assumes: one clock, asynchronous active-high reset
// Notes:   resets to the idle (high) level of active-low strobes
`timescale 1ns/1ns

module ahp_sync
#(
   parameter int W = 3
)
(
   // clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   // raw and synchronised levels
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);

   logic [W-1:0] meta_reg;  // first stage, read only by the second

   // both stages idle high so reset looks like no access
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         meta_reg <= '1;
         o_sync   <= '1;
      end
      else
      begin
         meta_reg <= i_async;
         o_sync   <= meta_reg;
      end
   end

endmodule

/* File: verif/ahp_host_model.sv */
// Purpose: host bus master model facing the host port
// Assumes: pins change 1 ns after the rising clock edge
// Notes:   released data lines show the inverse of the last value
`timescale 1ns/1ns

module ahp_host_model
   import ahp_pkg::*;
(
   // clock and port answer
   input  wire logic      i_clk,
   input  wire ahp_word_t i_data,
   input  wire logic      i_data_oe,
   // host pins
   output logic           o_cs_n,
   output logic           o_rd_n,
   output logic           o_wr_n,
   output logic [6:0]     o_addr,
   output logic           o_sel,
   output logic [1:0]     o_lane_n,
   output ahp_word_t      o_data
);
   // idle bus at time zero
   initial
   begin
      o_cs_n = 1'b1;
      o_rd_n = 1'b1;
      o_wr_n = 1'b1;
      o_addr = 7'h00;
      o_sel  = 1'b0;
      o_lane_n = 2'b11;
      o_data = 16'h0000;
   end

   // release strobes, then keep them high long enough to be seen
   task automatic idle();
      o_cs_n = 1'b1;
      o_rd_n = 1'b1;
      o_wr_n = 1'b1;
      o_data = ~o_data;
      repeat (4) @(posedge i_clk);
      #1;
   endtask

   // write: strobe held six clocks, no answer pin exists
   task automatic wr(input logic cs, input logic [6:0] a, input logic s, input logic [1:0] ln,
                     input ahp_word_t d);
      @(posedge i_clk);
      #1;
      o_cs_n   = cs;
      o_addr   = a;
      o_sel    = s;
      o_lane_n = ln;
      o_data   = d;
      o_wr_n   = 1'b0;
      repeat (6) @(posedge i_clk);
      #1;
      idle();
   endtask

   // read: hold until the port drives the bus, bounded wait
   task automatic rd(input logic cs, input logic [6:0] a, input logic s, output ahp_word_t d,
                     output logic ok);
      @(posedge i_clk);
      #1;
      o_cs_n = cs;
      o_addr = a;
      o_sel  = s;
      o_rd_n = 1'b0;
      ok     = 1'b0;
      d      = 16'h0000;
      for (int i = 0; i < 10 && !ok; i++)
      begin
         @(posedge i_clk);
         #1;
         ok = (i_data_oe === 1'b1);
      end
      d = i_data;
      idle();
   endtask
endmodule

/* File: verif/async_host_bus_port_tb.sv */
// Purpose: self-checking bench of the host port
// Assumes: 125 MHz clock, reset held six cycles
// Notes:   register space answers a pattern made from the word address
`timescale 1ns/1ns

module async_host_bus_port_tb;
   import ahp_pkg::*;
   logic       clk, rst, cs_n, rd_n, wr_n, sel, irq, oc, dma_en, tick, oe, int_o, int_oe, dma_req;
   logic [6:0] addr;
   logic [1:0] lane_n, lane_en, last_lane;
   ahp_word_t  din, dout, wd, last_wd, rdata;
   ahp_waddr_t raddr, last_addr;
   ahp_burst_t burst;
   ahp_delay_t gap;
   ahp_level_t level;
   logic       reg_wr, reg_rd;
   int         failures, check_count, wr_cnt, rd_cnt, cyc;

   // register space stand-in, valid while the read pulse is high
   assign rdata = {~raddr, 2'b10, raddr};

   ahp_port DUT (.I_CLK_SYS(clk), .I_RST(rst), .I_CS_N(cs_n), .I_READ_STROBE_N(rd_n),
      .I_WRITE_STROBE_N(wr_n), .I_ADDR(addr), .I_BUFFER_DMA_SELECT(sel), .I_BYTE_LANE_EN_N(lane_n),
      .I_DATA_I(din), .O_DATA_O(dout), .O_DATA_OE(oe), .O_INT_N_O(int_o), .O_INT_N_OE(int_oe),
      .O_DMA_REQUEST(dma_req), .O_REG_ADDR(raddr), .O_REG_WDATA(wd), .O_REG_BYTE_EN(lane_en),
      .O_REG_WR(reg_wr), .O_REG_RD(reg_rd), .I_REG_RDATA(rdata), .I_IRQ(irq),
      .I_INT_OPEN_COLLECTOR(oc), .I_DMA_ENABLE(dma_en), .I_DMA_BURST(burst), .I_DMA_GAP(gap),
      .I_SD_CLK_EN(tick), .I_RX_LEVEL(level));

   ahp_host_model host (.i_clk(clk), .i_data(dout), .i_data_oe(oe), .o_cs_n(cs_n), .o_rd_n(rd_n),
      .o_wr_n(wr_n), .o_addr(addr), .o_sel(sel), .o_lane_n(lane_n), .o_data(din));

   // count access pulses and keep what the last write carried
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (reg_rd === 1'b1)
         rd_cnt <= rd_cnt + 1;
      if (reg_wr === 1'b1)
      begin
         wr_cnt    <= wr_cnt + 1;
         last_addr <= raddr;
         last_wd   <= wd;
         last_lane <= lane_en;
      end
      if (cyc == 20000)
      begin
         failures++;
         $display("[ERR] %0t timeout", $time);
         conclude();
      end
   end

   task automatic cmp_w(input ahp_word_t got, input ahp_word_t exp);
      check_count++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %0t word got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic cmp_b(input logic got, input logic exp);
      check_count++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %0t bit got %b exp %b", $time, got, exp);
      end
   endtask

   // read one word and compare it with the pattern
   task automatic rd_chk(input logic [6:0] a, input logic s, input logic [6:0] wa);
      ahp_word_t d;
      logic      ok;
      int        n;
      n = rd_cnt;
      host.rd(1'b0, a, s, d, ok);
      cmp_b(ok, 1'b1);
      cmp_w(d, {~wa, 2'b10, wa});
      cmp_w(16'(rd_cnt - n), 16'h0001);
      cmp_b(oe, 1'b0);
   endtask

   // byte lanes in all four settings, then reads turning the bus round
   task automatic t_rw();
      int n;
      for (int i = 0; i < 4; i++)
      begin
         n = wr_cnt;
         host.wr(1'b0, 7'h40 + 7'(i), 1'b0, 2'(i), 16'ha55a ^ 16'(i));
         cmp_w(16'(wr_cnt - n), (i < 3) ? 16'h0001 : 16'h0000);
         if (i < 3)
         begin
            cmp_w({9'h000, last_addr}, 16'h0040 + 16'(i));
            cmp_w(last_wd, 16'ha55a ^ 16'(i));
            cmp_w({14'h0000, last_lane}, {14'h0000, ~2'(i)});
         end
      end
      rd_chk(7'h7f, 1'b0, 7'h7f);
      rd_chk(7'h00, 1'b0, 7'h00);
   endtask

   // strobes while unselected are ignored
   task automatic t_cs();
      ahp_word_t d;
      logic      ok;
      int        n;
      n = wr_cnt + rd_cnt;
      host.wr(1'b1, 7'h03, 1'b0, 2'b00, 16'h0f0f);
      host.rd(1'b1, 7'h03, 1'b0, d, ok);
      cmp_b(ok, 1'b0);
      cmp_w(16'(wr_cnt + rd_cnt - n), 16'h0000);
   endtask

   // dma request follows the fill, buffer accesses alternate ports
   task automatic t_dma();
      dma_en = 1'b1;
      burst  = 9'h004;
      level  = 11'h000;
      repeat (4) @(posedge clk);
      #1;
      cmp_b(dma_req, 1'b0);
      level = 11'h004;
      repeat (4) @(posedge clk);
      #1;
      cmp_b(dma_req, 1'b1);
      level = 11'h002;
      rd_chk(7'h5a, 1'b1, 7'h10);
      rd_chk(7'h01, 1'b1, 7'h11);
      rd_chk(7'h33, 1'b1, 7'h10);
      host.wr(1'b0, 7'h22, 1'b1, 2'b00, 16'hbeef);
      cmp_w({9'h000, last_addr}, 16'h0011);
      cmp_b(dma_req, 1'b0);
      rd_chk(7'h22, 1'b0, 7'h22);
      // a two-word burst drops the request, which returns after the gap
      dma_en = 1'b0;
      @(posedge clk);
      #1;
      dma_en = 1'b1;
      burst  = 9'h002;
      gap    = 7'h20;
      level  = 11'h004;
      repeat (3) @(posedge clk);
      #1;
      cmp_b(dma_req, 1'b1);
      rd_chk(7'h00, 1'b1, 7'h10);
      cmp_b(dma_req, 1'b1);
      rd_chk(7'h00, 1'b1, 7'h11);
      cmp_b(dma_req, 1'b0);
      repeat (80) @(posedge clk);
      #1;
      cmp_b(dma_req, 1'b1);
      dma_en = 1'b0;
      level  = 11'h000;
   endtask

   // interrupt in both output styles, then reset in mid-cycle
   task automatic t_irq_rst();
      irq = 1'b1;
      oc  = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      cmp_b(int_o, 1'b0);
      cmp_b(int_oe, 1'b1);
      irq = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      cmp_b(int_oe, 1'b0);
      oc  = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      cmp_b(int_o, 1'b1);
      cmp_b(int_oe, 1'b1);
      irq = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      cmp_b(int_o, 1'b0);
      cmp_b(int_oe, 1'b1);
      // reset rises between clock edges and must act at once
      rst = 1'b1;
      #1;
      cmp_b(int_o, 1'b1);
      cmp_b(int_oe, 1'b0);
      @(posedge clk);
      #1;
      rst = 1'b0;
      irq = 1'b0;
   endtask

   task automatic conclude();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // clock generator, 8 ns period
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // sd clock tick every other cycle
   always @(posedge clk)
      tick <= ~tick;

   // main sequence
   initial
   begin
      {rst, irq, oc, dma_en, tick} = 5'b10000;
      {burst, gap, level, failures, check_count, wr_cnt, rd_cnt, cyc} = '0;
      repeat (6) @(posedge clk);
      #1;
      rst = 1'b0;
      t_rw();
      t_cs();
      t_dma();
      t_irq_rst();
      rd_chk(7'h11, 1'b0, 7'h11);
      conclude();
   end
endmodule
